//--- pfti_disk_model.sv
module pfti_disk_model (
  input  wire logic        link_clk,
  input  wire logic        rst_n,
  input  wire logic        take,
  input  wire logic        skip,
  input  wire logic        fill_en,
  output logic      [31:0] data,
  output logic             fill,
  output logic      [19:0] time_sec,
  output int               taken
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC_WORDS = 2500;
  localparam logic [19:0] SEC_BASE = 20'h00100;
  int pos;
  assign pos = taken % SEC_WORDS;
  // Fill sits over the ten words around each second boundary: the last 5 of one second and the first 5 of the next
  assign fill = fill_en && (pos >= SEC_WORDS - 5 || pos < 5);
  assign time_sec = SEC_BASE + 20'(taken / SEC_WORDS);
  always @(posedge link_clk) begin
    if (!rst_n) begin
      taken <= 0;
      data <= 32'h0;
    end else begin
      taken <= taken + int'(take) + int'(skip);
      // Word valid the cycle after take; otherwise it keeps changing
      data <= take ? {taken[15:0], ~taken[15:0]} : ~data;
    end
  end
endmodule // pfti_disk_model

//--- pfti_hdr_mem.sv
// Frame-header store: written from the host clock, read with registered data at the link
module pfti_hdr_mem #(
  parameter int W  = 16,
  parameter int AW = 9
) (
  input  wire logic          wclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic          rclk,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_q
);
  logic [W-1:0] mem [2**AW];

  always_ff @(posedge wclk) begin
    if (we) mem[waddr] <= wdata;
  end

  always_ff @(posedge rclk) begin
    rdata_q <= mem[raddr];
  end
endmodule // pfti_hdr_mem

//--- pfti_pkg.sv
package pfti_pkg;

  // Disk-frame geometry and frame-header sizes
  localparam int DF_WORDS         = 2500;
  localparam int HDR_SAMPLES      = 240;
  localparam int NUM_CH           = 16;
  localparam int NUM_STREAMS      = 32;
  localparam int MAX_TAPE_SPEEDUP = 16;
  localparam int MIN_CF_PER_SEC   = 2;
  localparam int MAX_CF_PER_SEC   = 32;
  localparam int MODULE_CLK_HZ    = 32_000_000;

  // Widths
  localparam int WORD_W = 12;
  localparam int DFN_W  = 16;
  localparam int SCNT_W = 24;
  localparam int TC_W   = 20;
  localparam int DLY_W  = 16;
  localparam int RATE_W = 32;
  localparam int HDR_AW = 9;
  localparam int NCO_W  = 16;

  localparam logic [WORD_W-1:0] WORD_LAST = WORD_W'(DF_WORDS - 1);
  localparam logic [SCNT_W-1:0] HDR_LEN   = SCNT_W'(HDR_SAMPLES);

  // Interrupt cause bit positions
  localparam int NUM_IRQ  = 3;
  localparam int IRQ_TAPE = 0;
  localparam int IRQ_CF   = 1;
  localparam int IRQ_REF  = 2;

  // Magnitude value given to sign-only channels
  localparam logic MAG_FILL = 1'b1;

  typedef enum logic [1:0] {
    pfti_idle,
    pfti_arm,
    pfti_play
  } pfti_state_e;

  // Frame-start length 240*2^n for n = 1, 2, 4, 8, 16 (sel 0..4)
  function automatic logic [SCNT_W-1:0] pfti_frame_start_flag_len(input logic [2:0] sel);
    logic [SCNT_W-1:0] len;
    len = HDR_LEN;
    case (sel)
      3'h0:    pfti_frame_start_flag_len = len << 1;
      3'h1:    pfti_frame_start_flag_len = len << 2;
      3'h2:    pfti_frame_start_flag_len = len << 4;
      3'h3:    pfti_frame_start_flag_len = len << 8;
      default: pfti_frame_start_flag_len = len << 16;
    endcase
  endfunction

  // Low n streams active, n in 1..32
  function automatic logic [NUM_STREAMS-1:0] pfti_stream_mask(input logic [5:0] n);
    logic [NUM_STREAMS:0] ones;
    ones = (NUM_STREAMS+1)'(1) << n;
    pfti_stream_mask = NUM_STREAMS'(ones - (NUM_STREAMS+1)'(1));
  endfunction

endpackage

//--- pfti_playback_irq.sv
module pfti_playback_irq
  import pfti_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   play_run,
  input  wire logic                   su_mode,
  input  wire logic                   ref_irq_from_tape,
  input  wire logic [NUM_IRQ-1:0]     irq_mask,
  input  wire logic                   cause_rd,
  output logic      [NUM_IRQ-1:0]     cause_q,
  output logic                        host_irq_q,
  output logic      [31:0]            tape_second_counter_q,
  output logic      [TC_W-1:0]        tape_time_sec_q,
  input  wire logic [5:0]             active_streams,
  input  wire logic [SCNT_W-1:0]      cf_len,
  input  wire logic [2:0]             frame_start_flag_sel,
  input  wire logic [DFN_W-1:0]       df_per_sec,
  input  wire logic [NUM_CH-1:0]      sign_only,
  input  wire logic [NCO_W-1:0]       rate_inc,
  input  wire logic                   dly_load,
  input  wire logic [DLY_W-1:0]       dly_int,
  input  wire logic [RATE_W-1:0]      dly_rate,
  input  wire logic                   hdr_we,
  input  wire logic [HDR_AW-1:0]      hdr_addr,
  input  wire logic [NUM_CH-1:0]      hdr_wdata,
  input  wire logic                   output_ref_second_tick,
  input  wire logic                   link_clk,
  input  wire logic [NUM_STREAMS-1:0] link_data,
  input  wire logic                   link_fill,
  input  wire logic [TC_W-1:0]        link_time_sec,
  output logic                        link_take_q,
  output logic                        link_skip_q,
  output logic      [NUM_STREAMS-1:0] out_data_q,
  output logic                        frame_start_flag_q,
  output logic                        output_sample_clock_q
);

  logic [1:0]         ref_c_sync_q;
  logic               ref_c_prev_q;
  logic               run_prev_q;
  logic [DLY_W-1:0]   dly_int_hold_q;
  logic [RATE_W-1:0]  dly_rate_hold_q;
  logic [TC_W-1:0]    tcode_q;
  logic               tape_c_pulse;
  logic               cf_c_pulse;
  logic               link_rst_n;
  logic               tape_evt;
  logic               cf_evt;

  wire ref_c_edge = ref_c_sync_q[1] & ~ref_c_prev_q;
  wire run_rise   = play_run & ~run_prev_q;
  wire ref_src    = ref_irq_from_tape ? tape_c_pulse : ref_c_edge;

  wire [NUM_IRQ-1:0] cause_set = {play_run & ~su_mode & ref_src,
                                  play_run & su_mode & cf_c_pulse,
                                  play_run & tape_c_pulse};
  // New events beat a simultaneous read-clear
  wire [NUM_IRQ-1:0] cause_d = (cause_q & ~{NUM_IRQ{cause_rd}}) | cause_set;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_c_sync_q <= 2'b00;
      ref_c_prev_q <= 1'b0;
      run_prev_q   <= 1'b0;
      cause_q      <= '0;
      host_irq_q   <= 1'b0;
    end else begin
      ref_c_sync_q <= {ref_c_sync_q[0], output_ref_second_tick};
      ref_c_prev_q <= ref_c_sync_q[1];
      run_prev_q   <= play_run;
      cause_q      <= cause_d;
      host_irq_q   <= |(cause_d & irq_mask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tape_second_counter_q <= '0;
      tape_time_sec_q       <= '0;
      dly_int_hold_q        <= '0;
      dly_rate_hold_q       <= '0;
    end else begin
      if (run_rise) tape_second_counter_q <= '0;
      else if (tape_c_pulse) tape_second_counter_q <= tape_second_counter_q + 32'h1;
      // Link copy is stable for a whole tape second, far longer than the crossing
      if (tape_c_pulse) tape_time_sec_q <= tcode_q;
      if (dly_load) begin
        dly_int_hold_q  <= dly_int;
        dly_rate_hold_q <= dly_rate;
      end
    end
  end

  logic [1:0]              lrst_q;
  logic [1:0]              run_l_q;
  logic [1:0]              ref_l_q;
  logic                    ref_l_prev_q;
  pfti_state_e             state_q;
  logic                    cfg_su_q;
  logic [5:0]              cfg_streams_q;
  logic [SCNT_W-1:0]       cfg_cf_len_q;
  logic [2:0]              cfg_frame_start_flag_q;
  logic [DFN_W-1:0]        cfg_df_q;
  logic [NUM_CH-1:0]       cfg_sign_only_q;
  logic [NCO_W-1:0]        cfg_rate_q;
  logic [WORD_W-1:0]       word_q;
  logic [DFN_W-1:0]        dfn_q;
  logic [SCNT_W-1:0]       s_cnt_q;
  logic                    bank_q;
  logic [DLY_W-1:0]        pend_int_q;
  logic [RATE_W-1:0]       pend_rate_q;
  logic signed [DLY_W-1:0] cur_dly_q;
  logic signed [DLY_W-1:0] tgt_dly_q;
  logic [RATE_W-1:0]       rate_q;
  logic [RATE_W-1:0]       acc_q;
  logic [NCO_W-1:0]        nco_q;
  logic                    dly_l_pulse;
  logic [NUM_CH-1:0]       hdr_rdata_q;
  logic                    tape_tgl_q;
  logic                    cf_tgl_q;

  // Link reset is the core reset brought over by two flops
  always_ff @(posedge link_clk) lrst_q <= {lrst_q[0], rst_n};
  assign link_rst_n = lrst_q[1];

  wire ref_l_edge = ref_l_q[1] & ~ref_l_prev_q;
  wire playing    = state_q == pfti_play;
  wire start      = state_q == pfti_arm && ref_l_edge;
  wire word_last  = word_q == WORD_LAST;
  wire df_last    = dfn_q == cfg_df_q - DFN_W'(1);
  wire cf_last    = s_cnt_q == cfg_cf_len_q - SCNT_W'(1);
  wire dup        = cur_dly_q < tgt_dly_q;
  wire drop       = cur_dly_q > tgt_dly_q;

  // Word counting ignores header content, so ticks survive fill data
  assign tape_evt = start | (playing & link_take_q & word_last & df_last);
  assign cf_evt   = start | (playing & cfg_su_q & cf_last);
  wire apply_evt  = cfg_su_q ? cf_evt : (start | (playing & ref_l_edge));

  wire [SCNT_W-1:0] s_cnt_d = cf_evt ? '0 : s_cnt_q + SCNT_W'(1);
  wire              bank_d  = start ? 1'b0 : (cf_evt ? ~bank_q : bank_q);
  wire [HDR_AW-1:0] hdr_raddr = {bank_d, s_cnt_d[HDR_AW-2:0]};
  wire              hdr_win   = s_cnt_q < HDR_LEN;
  wire              frame_start_flag_d    = playing & cfg_su_q & (s_cnt_q < pfti_frame_start_flag_len(cfg_frame_start_flag_q));

  wire [RATE_W:0] acc_sum = {1'b0, acc_q} + {1'b0, rate_q};
  wire rate_neg = rate_q[RATE_W-1];
  wire tgt_up   = ~rate_neg & acc_sum[RATE_W];
  wire tgt_dn   = rate_neg & ~acc_sum[RATE_W];

  // Station-unit channel layout: sign on even, magnitude on odd
  logic [NUM_STREAMS-1:0] su_data;
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign su_data[2*c]   = link_data[2*c];
    assign su_data[2*c+1] = hdr_win ? hdr_rdata_q[c] :
                            (cfg_sign_only_q[c] ? MAG_FILL : link_data[2*c+1]);
  end
  wire [NUM_STREAMS-1:0] std_data = link_data & pfti_stream_mask(cfg_streams_q);
  wire [NUM_STREAMS-1:0] out_d    = !playing ? '0 : (cfg_su_q ? su_data : std_data);

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      run_l_q      <= 2'b00;
      ref_l_q      <= 2'b00;
      ref_l_prev_q <= 1'b0;
      state_q      <= pfti_idle;
    end else begin
      run_l_q      <= {run_l_q[0], play_run};
      ref_l_q      <= {ref_l_q[0], output_ref_second_tick};
      ref_l_prev_q <= ref_l_q[1];
      case (state_q)
        pfti_idle: if (run_l_q[1]) state_q <= pfti_arm;
        pfti_arm:  if (!run_l_q[1]) state_q <= pfti_idle;
                   else if (ref_l_edge) state_q <= pfti_play;
        pfti_play: if (!run_l_q[1]) state_q <= pfti_idle;
        default:   state_q <= pfti_idle;
      endcase
    end
  end

  // Configuration is static while running; sampled once on arming
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      cfg_su_q        <= 1'b0;
      cfg_streams_q   <= '0;
      cfg_cf_len_q    <= '0;
      cfg_frame_start_flag_q      <= '0;
      cfg_df_q        <= '0;
      cfg_sign_only_q <= '0;
      cfg_rate_q      <= '0;
    end else if (state_q == pfti_idle && run_l_q[1]) begin
      cfg_su_q        <= su_mode;
      cfg_streams_q   <= active_streams;
      cfg_cf_len_q    <= cf_len;
      cfg_frame_start_flag_q      <= frame_start_flag_sel;
      cfg_df_q        <= df_per_sec;
      cfg_sign_only_q <= sign_only;
      cfg_rate_q      <= rate_inc;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      word_q     <= '0;
      dfn_q      <= '0;
      s_cnt_q    <= '0;
      bank_q     <= 1'b0;
      tcode_q    <= '0;
      tape_tgl_q <= 1'b0;
      cf_tgl_q   <= 1'b0;
    end else begin
      if (start || (playing && link_take_q && word_last)) word_q <= '0;
      else if (playing && link_take_q) word_q <= word_q + WORD_W'(1);
      if (start || (playing && link_take_q && word_last && df_last)) dfn_q <= '0;
      else if (playing && link_take_q && word_last) dfn_q <= dfn_q + DFN_W'(1);
      if (start || (playing && cfg_su_q)) s_cnt_q <= s_cnt_d;
      bank_q <= bank_d;
      // Fill data carries no time code; keep the last good one
      if (tape_evt && !link_fill) tcode_q <= link_time_sec;
      if (tape_evt) tape_tgl_q <= ~tape_tgl_q;
      if (cf_evt) cf_tgl_q <= ~cf_tgl_q;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      pend_int_q  <= '0;
      pend_rate_q <= '0;
      cur_dly_q   <= '0;
      tgt_dly_q   <= '0;
      rate_q      <= '0;
      acc_q       <= '0;
    end else begin
      // Hold registers are quiet until the next load, so the copy is safe
      if (dly_l_pulse) begin
        pend_int_q  <= dly_int_hold_q;
        pend_rate_q <= dly_rate_hold_q;
      end
      if (apply_evt) begin
        tgt_dly_q <= pend_int_q;
        rate_q    <= cfg_su_q ? pend_rate_q : '0;
        acc_q     <= '0;
      end else if (playing) begin
        acc_q <= acc_sum[RATE_W-1:0];
        if (tgt_up) tgt_dly_q <= tgt_dly_q + DLY_W'(1);
        else if (tgt_dn) tgt_dly_q <= tgt_dly_q - DLY_W'(1);
      end
      if (start) cur_dly_q <= pend_int_q;
      else if (playing && dup) cur_dly_q <= cur_dly_q + DLY_W'(1);
      else if (playing && drop) cur_dly_q <= cur_dly_q - DLY_W'(1);
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      link_take_q           <= 1'b0;
      link_skip_q           <= 1'b0;
      out_data_q            <= '0;
      frame_start_flag_q    <= 1'b0;
      output_sample_clock_q <= 1'b0;
      nco_q                 <= '0;
    end else begin
      link_take_q        <= playing & ~dup;
      link_skip_q        <= playing & drop;
      out_data_q         <= out_d;
      frame_start_flag_q <= frame_start_flag_d;
      nco_q              <= nco_q + cfg_rate_q;
      // Station-unit clock is a fixed half of the link clock, not the data rate
      output_sample_clock_q <= cfg_su_q ? ~output_sample_clock_q : nco_q[NCO_W-1];
    end
  end

  pfti_hdr_mem #(.W(NUM_CH), .AW(HDR_AW)) u_hdr (
    .wclk(core_clk), .we(hdr_we), .waddr(hdr_addr), .wdata(hdr_wdata),
    .rclk(link_clk), .raddr(hdr_raddr), .rdata_q(hdr_rdata_q));
  // Tick and frame events are far apart (>= 1/512 s), so toggles keep up
  pfti_pulse_sync u_tape_sync (
    .src_clk(link_clk), .src_rst_n(link_rst_n), .src_pulse(tape_evt),
    .dst_clk(core_clk), .dst_rst_n(rst_n), .dst_pulse(tape_c_pulse));
  pfti_pulse_sync u_cf_sync (
    .src_clk(link_clk), .src_rst_n(link_rst_n), .src_pulse(cf_evt),
    .dst_clk(core_clk), .dst_rst_n(rst_n), .dst_pulse(cf_c_pulse));
  pfti_pulse_sync u_dly_sync (
    .src_clk(core_clk), .src_rst_n(rst_n), .src_pulse(dly_load),
    .dst_clk(link_clk), .dst_rst_n(link_rst_n), .dst_pulse(dly_l_pulse));

  AST_CAUSE_RD_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    cause_rd && cause_set == '0 |=> cause_q == '0) else $error("cause not cleared by read");
  AST_IRQ_MASK: assert property (@(posedge core_clk) disable iff (!rst_n)
    host_irq_q |-> |(cause_q & $past(irq_mask))) else $error("irq from masked source");
  AST_TAPE_COUNT: assert property (@(posedge core_clk) disable iff (!rst_n)
    tape_c_pulse && !run_rise |=> tape_second_counter_q == $past(tape_second_counter_q) + 32'h1)
    else $error("tape counter not incremented");
  AST_COUNT_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    run_rise |=> tape_second_counter_q == '0) else $error("tape counter not cleared");
  AST_REF_STD_ONLY: assert property (@(posedge core_clk) disable iff (!rst_n)
    cause_q[IRQ_REF] && !$past(cause_q[IRQ_REF]) |-> $past(play_run && !su_mode))
    else $error("ref irq outside standard play");
  AST_START_EVENTS: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    start |=> cf_tgl_q != $past(cf_tgl_q) && tape_tgl_q != $past(tape_tgl_q))
    else $error("no events at playback start");
  AST_FRAME_START_FLAG_HIGH: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    playing && cfg_su_q && s_cnt_q == '0 |=> frame_start_flag_q) else $error("frame flag low");
  AST_HDR_MAG: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    playing && cfg_su_q && hdr_win |=> out_data_q[1] == $past(hdr_rdata_q[0]))
    else $error("header not on magnitude stream");
  AST_STD_MASK: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    !cfg_su_q |=> (out_data_q & ~pfti_stream_mask($past(cfg_streams_q))) == '0)
    else $error("inactive stream driven");
  AST_DUP_STALL: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    playing && dup |=> !link_take_q && cur_dly_q == $past(cur_dly_q) + DLY_W'(1))
    else $error("duplicate not stalled");

endmodule // pfti_playback_irq

//--- pfti_pulse_sync.sv
// Event crossing: toggle in source domain, two flops plus edge flop in destination
module pfti_pulse_sync (
  input  wire logic src_clk,
  input  wire logic src_rst_n,
  input  wire logic src_pulse,
  input  wire logic dst_clk,
  input  wire logic dst_rst_n,
  output logic      dst_pulse
);
  logic       tgl_q;
  logic [1:0] sync_q;
  logic       prev_q;

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) tgl_q <= 1'b0;
    else if (src_pulse) tgl_q <= ~tgl_q;
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      sync_q <= 2'b00;
      prev_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], tgl_q};
      prev_q <= sync_q[1];
    end
  end

  assign dst_pulse = sync_q[1] ^ prev_q;
endmodule // pfti_pulse_sync

//--- tb_playback_frame_timing_irq.sv
module tb_playback_frame_timing_irq;
  import pfti_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, link_clk, play_run, su_mode, ref_irq_from_tape, output_ref_second_tick = 1'b0;
  logic rst_n, hdr_we, host_irq_q, link_take_q, link_skip_q, frame_start_flag_q, link_fill;
  logic cause_rd = 1'b0;
  logic dly_load = 1'b0;
  logic [15:0] dly_int = 16'h0000;
  logic sc_prev, output_sample_clock_q;
  logic fill_en, fs_prev;
  logic [2:0] irq_mask, frame_start_flag_sel, cause_q;
  logic [5:0] active_streams;
  logic [23:0] cf_len;
  logic [15:0] df_per_sec, sign_only, rate_inc, hdr_wdata, hdr0, lfsr_q, mag;
  logic [8:0] hdr_addr;
  logic [31:0] link_data, out_data_q, tape_second_counter_q;
  logic [19:0] link_time_sec, tape_time_sec_q, exp_t;
  int taken, taken0, error_cnt, n_tests, n_fs, fs_run;
  int ref_cnt = 0;
  int n_ev[3];

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #2.1;
    forever #3 link_clk = ~link_clk;
  end

  pfti_playback_irq DUT (.core_clk, .rst_n, .play_run, .su_mode, .ref_irq_from_tape,
    .irq_mask, .cause_rd, .cause_q, .host_irq_q, .tape_second_counter_q, .tape_time_sec_q,
    .active_streams, .cf_len, .frame_start_flag_sel, .df_per_sec, .sign_only, .rate_inc,
    .dly_load, .dly_int, .dly_rate(32'h00000000), .hdr_we, .hdr_addr,
    .hdr_wdata, .output_ref_second_tick, .link_clk, .link_data, .link_fill, .link_time_sec,
    .link_take_q, .link_skip_q, .out_data_q, .frame_start_flag_q, .output_sample_clock_q);

  pfti_disk_model u_disk (.link_clk(link_clk), .rst_n(rst_n), .take(link_take_q),
    .skip(link_skip_q), .fill_en(fill_en), .data(link_data), .fill(link_fill),
    .time_sec(link_time_sec), .taken(taken));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Reference second pin: period 300 core cycles
  always @(posedge core_clk) begin
    ref_cnt <= (ref_cnt == 299) ? 0 : ref_cnt + 1;
    output_ref_second_tick <= ref_cnt < 10;
  end

  // Host model: counts causes and read-clears them
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cause_rd <= 1'b0;
    end else begin
      chk("host_irq_q", 32'(|(cause_q & irq_mask)), 32'(host_irq_q));
      cause_rd <= (|cause_q) && !cause_rd;
      // Count what each read returns; a set in the read cycle waits for the next read
      if (cause_rd) begin
        for (int i = 0; i < 3; i++) n_ev[i] += int'(cause_q[i]);
      end
    end
  end

  // Far-side watch of the output samples
  always @(posedge link_clk) begin
    fs_prev <= frame_start_flag_q;
    for (int c = 0; c < NUM_CH; c++) mag[c] = out_data_q[2*c+1];
    if (frame_start_flag_q && !fs_prev) begin
      if (n_fs == 0) chk("hdr mag", 32'(hdr0), 32'(mag));
      n_fs++;
      fs_run <= 1;
    end else if (frame_start_flag_q) begin
      fs_run <= fs_run + 1;
    end else if (fs_prev && play_run) begin
      chk("flag len", 32'(240 << (1 << frame_start_flag_sel)), 32'(fs_run));
      chk("mag fill", 32'(MAG_FILL), 32'(out_data_q[1]));
    end
    if (rst_n && !su_mode) begin
      chk("std flag", 32'h0, 32'(frame_start_flag_q));
      chk("std streams", 32'h0, {8'h00, out_data_q[31:8]});
    end
    if (rst_n) chk("skip", 32'h0, 32'(link_skip_q));
    if (play_run && su_mode && fs_run > 0)
      chk("sample clk", 32'(!sc_prev), 32'(output_sample_clock_q));
    sc_prev <= output_sample_clock_q;
  end

  task automatic run(input logic su, input logic [2:0] sel, input logic fe);
    @(posedge core_clk);
    su_mode <= su;
    frame_start_flag_sel <= sel;
    fill_en <= fe;
    active_streams <= su ? 6'h20 : 6'h08;
    irq_mask <= lfsr_q[2:0];
    ref_irq_from_tape <= lfsr_q[3];
    lfsr_q = lfsr(lfsr_q);
    n_ev = '{0, 0, 0};
    n_fs = 0;
    taken0 = taken;
    repeat (4) @(posedge core_clk);
    play_run <= 1'b1;
    repeat (400) @(posedge core_clk);
    // Larger delay mid-scan: the next frame boundary must stall the take strobe
    dly_load <= (sel == 3'h1) && su;
    dly_int <= 16'h0002;
    @(posedge core_clk);
    dly_load <= 1'b0;
    repeat (799) @(posedge core_clk);
    play_run <= 1'b0;
    repeat (60) @(posedge core_clk);
    chk("tape counter", 32'(n_ev[0]), tape_second_counter_q);
    chk("tape ticks", 32'(1 + (taken - taken0) / DF_WORDS), 32'(n_ev[0]));
    if (su) begin
      chk("cf events", 32'(n_fs), 32'(n_ev[1]));
      chk("ref in su", 32'h0, 32'(n_ev[2]));
    end else begin
      chk("cf in std", 32'h0, 32'(n_ev[1]));
      chk("ref seen", 32'h1, 32'(n_ev[2] > 0));
      exp_t = link_time_sec;
      chk("tape time", 32'h1, 32'(tape_time_sec_q <= exp_t && tape_time_sec_q + 2 >= exp_t));
    end
    $display("test su=%0d sel=%0d fill=%0d ended", su, sel, fe);
  endtask

  initial begin
    rst_n = 1'b0;
    play_run = 1'b0;
    su_mode = 1'b1;
    ref_irq_from_tape = 1'b0;
    irq_mask = 3'h7;
    active_streams = 6'h20;
    cf_len = 24'h0003E8;
    frame_start_flag_sel = 3'h0;
    df_per_sec = 16'h0001;
    sign_only = 16'h0001;
    rate_inc = 16'h8000;
    hdr_we = 1'b0;
    hdr_addr = 9'h000;
    hdr_wdata = 16'h0000;
    fill_en = 1'b0;
    lfsr_q = 16'hC6C5;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("reset cause", 32'h0, 32'(cause_q));
    chk("reset counter", 32'h0, tape_second_counter_q);
    repeat (3) @(posedge core_clk);
    // Both header banks, so every frame carries defined magnitude bits
    for (int i = 0; i < 2 ** HDR_AW; i++) begin
      @(posedge core_clk);
      hdr_we <= 1'b1;
      hdr_addr <= 9'(i);
      hdr_wdata <= lfsr_q;
      if (i == 0) hdr0 = lfsr_q;
      lfsr_q = lfsr(lfsr_q);
    end
    @(posedge core_clk);
    hdr_we <= 1'b0;
    run(1'b1, 3'h0, 1'b1);
    run(1'b1, 3'h1, 1'b0);
    run(1'b0, 3'h0, 1'b0);
    print_verdict();
  end

  initial begin
    repeat (8000) @(posedge core_clk);
    error_cnt++;
    $display("unexpected watchdog: expected end seen timeout");
    print_verdict();
  end
endmodule // tb_playback_frame_timing_irq
